// ==== rtl/sbafe_dev.sv ====
`timescale 1ns/1ps
// Function
// - host should load preferred mode word
// - per-channel enable routes channels two to four
// - per-channel disabled: one code for all
// - codes map 200, 100, 50, 25 kilohm
// - path word: full path or TIA-ADC only
// - status high byte shows FIFO bytes
// - bytes versus words: factor two compare
// - bit 15 write clears FIFO if enabled
// - slot B flag set, write-one clears
// - slot A flag set, write-one clears
// - slot B event forwarded when unmasked
// - FIFO interrupt while words exceed threshold
module sbafe_dev
    import sbafe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    sbafe_link_if.dev link,
    input wire logic [7:0] fifo_byte_count,
    input wire logic fifo_host_access_enable,
    input wire logic [5:0] fifo_word_threshold,
    input wire logic first_slot_sample_done,
    input wire logic second_slot_sample_done,
    input wire logic second_slot_event_mask,
    output logic [15:0] second_slot_frontend_mode,
    output logic [15:0] second_slot_path_select,
    output logic path_full_mode,
    output logic path_tia_mode,
    output logic [3:0][1:0] channel_gain_code,
    output logic [3:0][7:0] channel_gain_kohm,
    output logic fifo_clear,
    output logic fifo_irq,
    output logic second_slot_irq,
    output logic first_slot_event_flag,
    output logic second_slot_event_flag
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] gain;
        logic [15:0] path;
        logic [15:0] chgain;
        logic flag_a;
        logic flag_b;
        logic fifo_clr;
        logic ack;
        logic [15:0] rdata;
        logic [3:0][1:0] ch_code;
        logic [3:0][7:0] ch_kohm;
        logic path_full;
        logic path_tia;
        logic fifo_irq;
        logic slot_b_irq;
    } sbafe_dev_st_t;

    sbafe_dev_st_t st_r;
    sbafe_dev_st_t st_nxt;

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    function automatic logic [15:0] read_word(
        input logic [7:0] a,
        input sbafe_dev_st_t s,
        input logic [7:0] cnt
    );
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            SBAFE_ADDR_STATUS: begin
                v[SBAFE_COUNT_LSB +: 8] = cnt;
                v[SBAFE_BIT_FLAG_B] = s.flag_b;
                v[SBAFE_BIT_FLAG_A] = s.flag_a;
            end
            SBAFE_ADDR_MODE: v = s.mode;
            SBAFE_ADDR_GAIN: v = s.gain;
            SBAFE_ADDR_PATH: v = s.path;
            SBAFE_ADDR_CHGAIN: v = s.chgain;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic ind_en;
        logic [6:0] words;
        ind_en = 1'b0;
        words = 7'h00;
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.fifo_clr = 1'b0;

        if (link.req) begin
            st_nxt.ack = 1'b1;
            if (link.we) begin
                unique case (link.addr)
                    SBAFE_ADDR_STATUS: begin
                        // only flag and clear bits act
                        if (link.wdata[SBAFE_BIT_FLAG_B]) begin
                            st_nxt.flag_b = 1'b0;
                        end
                        if (link.wdata[SBAFE_BIT_FLAG_A]) begin
                            st_nxt.flag_a = 1'b0;
                        end
                        if (link.wdata[SBAFE_BIT_FIFO_CLR] && fifo_host_access_enable) begin
                            st_nxt.fifo_clr = 1'b1;
                        end
                    end
                    SBAFE_ADDR_MODE: st_nxt.mode = link.wdata;
                    SBAFE_ADDR_GAIN: st_nxt.gain = link.wdata;
                    SBAFE_ADDR_PATH: st_nxt.path = link.wdata;
                    SBAFE_ADDR_CHGAIN: st_nxt.chgain = link.wdata;
                    default: ;
                endcase
            end else begin
                st_nxt.rdata = read_word(link.addr, st_r, fifo_byte_count);
            end
        end

        if (second_slot_sample_done) begin
            st_nxt.flag_b = 1'b1;
        end
        if (first_slot_sample_done) begin
            st_nxt.flag_a = 1'b1;
        end

        st_nxt.slot_b_irq = second_slot_sample_done && !second_slot_event_mask;

        words = fifo_byte_count[7:1];
        st_nxt.fifo_irq = words > {1'b0, fifo_word_threshold};

        // gain routing from the current register values
        ind_en = st_r.gain[SBAFE_BIT_IND_EN];
        st_nxt.ch_code[0] = st_r.gain[SBAFE_GAIN_LSB +: 2];
        if (ind_en) begin
            st_nxt.ch_code[1] = st_r.chgain[SBAFE_CH2_LSB +: 2];
            st_nxt.ch_code[2] = st_r.chgain[SBAFE_CH3_LSB +: 2];
            st_nxt.ch_code[3] = st_r.chgain[SBAFE_CH4_LSB +: 2];
        end else begin
            st_nxt.ch_code[1] = st_r.gain[SBAFE_GAIN_LSB +: 2];
            st_nxt.ch_code[2] = st_r.gain[SBAFE_GAIN_LSB +: 2];
            st_nxt.ch_code[3] = st_r.gain[SBAFE_GAIN_LSB +: 2];
        end
        for (int i = 0; i < 4; i++) begin
            st_nxt.ch_kohm[i] = sbafe_gain_kohm(st_r.ch_code[i]);
        end

        st_nxt.path_full = st_r.path == SBAFE_PATH_FULL;
        st_nxt.path_tia = st_r.path == SBAFE_PATH_TIA;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // mode word comes up at default
            st_r.mode <= SBAFE_MODE_RST;
            st_r.gain <= SBAFE_GAIN_RST;
            st_r.path <= SBAFE_PATH_FULL;
            st_r.chgain <= SBAFE_CHGAIN_RST;
            st_r.flag_a <= 1'b0;
            st_r.flag_b <= 1'b0;
            st_r.fifo_clr <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.ch_code <= '0;
            st_r.ch_kohm <= {4{8'hC8}};
            st_r.path_full <= 1'b1;
            st_r.path_tia <= 1'b0;
            st_r.fifo_irq <= 1'b0;
            st_r.slot_b_irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.ack = st_r.ack;
    assign link.rdata = st_r.rdata;
    assign second_slot_frontend_mode = st_r.mode;
    assign second_slot_path_select = st_r.path;
    assign path_full_mode = st_r.path_full;
    assign path_tia_mode = st_r.path_tia;
    assign channel_gain_code = st_r.ch_code;
    assign channel_gain_kohm = st_r.ch_kohm;
    assign fifo_clear = st_r.fifo_clr;
    assign fifo_irq = st_r.fifo_irq;
    assign second_slot_irq = st_r.slot_b_irq;
    assign first_slot_event_flag = st_r.flag_a;
    assign second_slot_event_flag = st_r.flag_b;

endmodule // sbafe_dev

// ==== shared/sbafe_pkg.sv ====
package sbafe_pkg;

    // ----------------------------------------------------------------
    // device register offsets on the link
    // ----------------------------------------------------------------
    localparam logic [7:0] SBAFE_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SBAFE_ADDR_MODE = 8'h3B;
    localparam logic [7:0] SBAFE_ADDR_GAIN = 8'h44;
    localparam logic [7:0] SBAFE_ADDR_PATH = 8'h45;
    localparam logic [7:0] SBAFE_ADDR_CHGAIN = 8'h55;

    // ----------------------------------------------------------------
    // reset values and recommended values
    // ----------------------------------------------------------------
    localparam logic [15:0] SBAFE_MODE_RST = 16'h22FC;
    localparam logic [15:0] SBAFE_MODE_PREFERRED = 16'h21F4;
    localparam logic [15:0] SBAFE_GAIN_RST = 16'h1C38;
    localparam logic [15:0] SBAFE_PATH_FULL = 16'hADA5;
    localparam logic [15:0] SBAFE_PATH_TIA = 16'hB065;
    localparam logic [15:0] SBAFE_CHGAIN_RST = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SBAFE_BIT_IND_EN = 6;
    localparam int SBAFE_GAIN_LSB = 0;
    localparam int SBAFE_CH2_LSB = 6;
    localparam int SBAFE_CH3_LSB = 8;
    localparam int SBAFE_CH4_LSB = 10;
    localparam int SBAFE_BIT_FLAG_A = 5;
    localparam int SBAFE_BIT_FLAG_B = 6;
    localparam int SBAFE_BIT_FIFO_CLR = 15;
    localparam int SBAFE_COUNT_LSB = 8;

    // ----------------------------------------------------------------
    // controller registers on the AHB-Lite side (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [3:0] SBAFE_HOFS_CMD = 4'h0;
    localparam logic [3:0] SBAFE_HOFS_WDATA = 4'h4;
    localparam logic [3:0] SBAFE_HOFS_RDATA = 4'h8;
    localparam logic [3:0] SBAFE_HOFS_STATUS = 4'hC;
    localparam int SBAFE_CMD_WE_BIT = 8;
    localparam int SBAFE_CMD_GO_BIT = 9;

    // gain code to transimpedance in kilohm
    function automatic logic [7:0] sbafe_gain_kohm(input logic [1:0] code);
        unique case (code)
            2'h0: sbafe_gain_kohm = 8'hC8;
            2'h1: sbafe_gain_kohm = 8'h64;
            2'h2: sbafe_gain_kohm = 8'h32;
            2'h3: sbafe_gain_kohm = 8'h19;
        endcase
    endfunction

endpackage

// ==== shared/sbafe_link_if.sv ====
`timescale 1ns/1ps
interface sbafe_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack
    );
endinterface

// ==== rtl/sbafe_host.sv ====
`timescale 1ns/1ps
module sbafe_host
    import sbafe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    sbafe_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_WAIT} sbafe_hst_t;

    typedef struct packed {
        sbafe_hst_t st;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [7:0] cmd_addr;
        logic cmd_we;
        logic [15:0] cmd_wdata;
        logic [15:0] rd_cap;
        logic busy;
        logic done;
        logic err;
        logic init_done;
        logic wr_pend;
        logic [3:0] wr_ofs;
        logic [31:0] hrdata;
        logic hready;
    } sbafe_host_st_t;

    sbafe_host_st_t st_r;
    sbafe_host_st_t st_nxt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic go;
        logic bad;
        go = 1'b0;
        bad = 1'b0;
        st_nxt = st_r;
        st_nxt.req = 1'b0;
        st_nxt.hready = 1'b1;

        // ahb data phase of a write
        st_nxt.wr_pend = 1'b0;
        if (st_r.wr_pend) begin
            unique case (st_r.wr_ofs)
                SBAFE_HOFS_CMD: begin
                    st_nxt.cmd_addr = hwdata[7:0];
                    st_nxt.cmd_we = hwdata[SBAFE_CMD_WE_BIT];
                    go = hwdata[SBAFE_CMD_GO_BIT] && (st_r.st == ST_IDLE);
                end
                SBAFE_HOFS_WDATA: st_nxt.cmd_wdata = hwdata[15:0];
                default: ;
            endcase
        end

        // ahb address phase
        if (hsel && htrans[1] && hready) begin
            st_nxt.hrdata = 32'h0000_0000;
            if (hwrite) begin
                st_nxt.wr_pend = 1'b1;
                st_nxt.wr_ofs = haddr[3:0];
            end else begin
                unique case (haddr[3:0])
                    SBAFE_HOFS_CMD: st_nxt.hrdata = {22'h0, 1'b0, st_r.cmd_we, st_r.cmd_addr};
                    SBAFE_HOFS_WDATA: st_nxt.hrdata = {16'h0, st_r.cmd_wdata};
                    SBAFE_HOFS_RDATA: st_nxt.hrdata = {16'h0, st_r.rd_cap};
                    SBAFE_HOFS_STATUS: begin
                        st_nxt.hrdata = {28'h0, st_r.init_done, st_r.err, st_r.done, st_r.busy};
                    end
                    default: st_nxt.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // link sequencing
        unique case (st_r.st)
            ST_INIT: begin
                st_nxt.req = 1'b1;
                st_nxt.we = 1'b1;
                st_nxt.addr = SBAFE_ADDR_MODE;
                st_nxt.wdata = SBAFE_MODE_PREFERRED;
                st_nxt.busy = 1'b1;
                st_nxt.st = ST_WAIT;
            end
            ST_IDLE: begin
                if (go) begin
                    bad = hwdata[SBAFE_CMD_WE_BIT] && (hwdata[7:0] == SBAFE_ADDR_PATH)
                        && (st_r.cmd_wdata != SBAFE_PATH_FULL)
                        && (st_r.cmd_wdata != SBAFE_PATH_TIA);
                    st_nxt.done = bad;
                    st_nxt.err = bad;
                    if (!bad) begin
                        st_nxt.req = 1'b1;
                        st_nxt.we = hwdata[SBAFE_CMD_WE_BIT];
                        st_nxt.addr = hwdata[7:0];
                        st_nxt.wdata = st_r.cmd_wdata;
                        st_nxt.busy = 1'b1;
                        st_nxt.st = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (link.ack) begin
                    st_nxt.rd_cap = link.rdata;
                    st_nxt.busy = 1'b0;
                    st_nxt.done = st_r.init_done;
                    st_nxt.init_done = 1'b1;
                    st_nxt.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.st <= ST_INIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.req = st_r.req;
    assign link.we = st_r.we;
    assign link.addr = st_r.addr;
    assign link.wdata = st_r.wdata;
    assign hrdata = st_r.hrdata;
    assign hreadyout = st_r.hready;
    assign hresp = 1'b0;

endmodule // sbafe_host

// ==== rtl/sbafe_unused.sv ====
`timescale 1ns/1ps

// ==== verification/sbafe_checker.sv ====
`timescale 1ns/1ps
module sbafe_checker
    import sbafe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic [7:0] fifo_byte_count,
    input wire logic fifo_host_access_enable,
    input wire logic [5:0] fifo_word_threshold,
    input wire logic first_slot_sample_done,
    input wire logic second_slot_sample_done,
    input wire logic second_slot_event_mask,
    input wire logic [15:0] second_slot_path_select,
    input wire logic path_full_mode,
    input wire logic path_tia_mode,
    input wire logic [3:0][1:0] channel_gain_code,
    input wire logic [3:0][7:0] channel_gain_kohm,
    input wire logic fifo_clear,
    input wire logic fifo_irq,
    input wire logic second_slot_irq,
    input wire logic first_slot_event_flag,
    input wire logic second_slot_event_flag
);
    logic clr_b;
    logic clr_f;
    assign clr_b = req && we && (addr == SBAFE_ADDR_STATUS) && wdata[SBAFE_BIT_FLAG_B];
    assign clr_f = req && we && (addr == SBAFE_ADDR_STATUS) && wdata[SBAFE_BIT_FIFO_CLR]
        && fifo_host_access_enable;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------------
    // link sequences
    // ----------------------------------------------------------------
    sequence s_gain_wr;
        req && we && (addr == SBAFE_ADDR_GAIN);
    endsequence
    sequence s_clr_b;
        clr_b && !second_slot_sample_done ##1 !second_slot_sample_done;
    endsequence
    sequence s_stat_rd;
        req && !we && (addr == SBAFE_ADDR_STATUS) ##1 ack;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_GAIN_CH1:
        assert property (s_gain_wr |-> ##3 channel_gain_code[0] == $past(wdata[1:0], 3))
        else $error("channel one gain wrong");
    AST_GAIN_ALL:
        assert property (s_gain_wr and !wdata[SBAFE_BIT_IND_EN]
            |-> ##3 channel_gain_code == {4{$past(wdata[1:0], 3)}})
        else $error("shared gain not applied");
    AST_KOHM:
        assert property (1'b1 |=> channel_gain_kohm[3] == (8'hC8 >> $past(channel_gain_code[3]))
            && channel_gain_kohm[1] == (8'hC8 >> $past(channel_gain_code[1])))
        else $error("kohm decode wrong");
    AST_PATH:
        assert property (1'b1 |=> path_full_mode == ($past(second_slot_path_select) == SBAFE_PATH_FULL)
            && path_tia_mode == ($past(second_slot_path_select) == SBAFE_PATH_TIA))
        else $error("path decode wrong");
    AST_COUNT:
        assert property (s_stat_rd |-> rdata[15:8] == $past(fifo_byte_count))
        else $error("status byte count wrong");
    AST_FIFO_IRQ:
        assert property (1'b1 |=> fifo_irq == (($past(fifo_byte_count) >> 1) > $past(fifo_word_threshold)))
        else $error("fifo irq wrong");
    AST_FIFO_CLR_DO:
        assert property (clr_f |-> ##[1:2] fifo_clear)
        else $error("fifo clear missing");
    AST_FIFO_CLR_WHY:
        assert property (fifo_clear |-> $past(clr_f) || $past(clr_f, 2))
        else $error("fifo clear without cause");
    AST_FLAG_B_SET:
        assert property (second_slot_sample_done |=> second_slot_event_flag)
        else $error("slot b flag not set");
    AST_FLAG_B_CLR:
        assert property (s_clr_b |=> !second_slot_event_flag)
        else $error("slot b flag not cleared");
    AST_FLAG_B_HOLD:
        assert property ($fell(second_slot_event_flag) |-> $past(clr_b) || $past(clr_b, 2))
        else $error("slot b flag dropped");
    AST_FLAG_A_SET:
        assert property (first_slot_sample_done |=> first_slot_event_flag)
        else $error("slot a flag not set");
    AST_SLOT_B_IRQ:
        assert property (second_slot_sample_done |=> second_slot_irq == !$past(second_slot_event_mask))
        else $error("slot b irq wrong");
    AST_RSVD_ZERO:
        assert property (s_stat_rd |-> rdata[7] == 1'b0 && rdata[4:0] == 5'h00)
        else $error("reserved status bits set");
endmodule // sbafe_checker

// ==== verification/slot_b_afe_cfg_and_status_tb.sv ====
`timescale 1ns/1ps
module slot_b_afe_cfg_and_status_tb;
    import sbafe_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] fifo_byte_count;
    logic [5:0] fifo_word_threshold;
    logic fifo_host_access_enable, first_slot_sample_done, second_slot_sample_done;
    logic second_slot_event_mask, path_full_mode, path_tia_mode, fifo_clear, fifo_irq;
    logic second_slot_irq, first_slot_event_flag, second_slot_event_flag;
    logic [15:0] second_slot_frontend_mode, second_slot_path_select, r;
    logic [3:0][1:0] channel_gain_code;
    logic [3:0][7:0] channel_gain_kohm;
    logic [3:0] st;
    int mismatches = 0;
    int total_checks = 0;
    int clr_cnt = 0;
    int irq_cnt = 0;

    sbafe_link_if link();
    sbafe_dev sbafe_dev_inst (.link(link), .*);
    sbafe_host sbafe_host_inst (.link(link), .hready(hreadyout), .*);
    sbafe_checker sbafe_checker_inst (.req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .*);

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        x = hrdata;
    endtask

    task automatic lnk(input logic w, input logic [7:0] a, input logic [15:0] d);
        ahb(1'b1, SBAFE_HOFS_WDATA, {16'h0, d});
        ahb(1'b1, SBAFE_HOFS_CMD, {22'h0, 1'b1, w, a});
        repeat (3) @(posedge hclk);
        do ahb(1'b0, SBAFE_HOFS_STATUS, 32'h0); while (x[0] !== 1'b0);
        st = x[3:0];
        ahb(1'b0, SBAFE_HOFS_RDATA, 32'h0);
        r = x[15:0];
    endtask

    task automatic st_rw(input logic [15:0] d, input logic [15:0] e);
        lnk(1'b1, SBAFE_ADDR_STATUS, d);
        lnk(1'b0, SBAFE_ADDR_STATUS, 16'h0);
        chk("status", e, r);
    endtask

    task automatic pulse(input logic b);
        if (b) second_slot_sample_done <= 1'b1;
        else first_slot_sample_done <= 1'b1;
        @(posedge hclk);
        second_slot_sample_done <= 1'b0;
        first_slot_sample_done <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_init();
        lnk(1'b0, SBAFE_ADDR_MODE, 16'h0);
        chk("mode_rd", SBAFE_MODE_PREFERRED, r);
        chk("mode_out", SBAFE_MODE_PREFERRED, second_slot_frontend_mode);
        lnk(1'b0, SBAFE_ADDR_PATH, 16'h0);
        chk("path_rd", SBAFE_PATH_FULL, r);
        chk("full", 1'b1, path_full_mode);
    endtask

    task automatic t_gain();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            lnk(1'b1, SBAFE_ADDR_GAIN, (SBAFE_GAIN_RST & 16'hFFBC) | {14'h0, c});
            repeat (4) @(posedge hclk);
            for (int k = 0; k < 4; k++) begin
                chk("code", c, channel_gain_code[k]);
                chk("kohm", 8'hC8 >> c, channel_gain_kohm[k]);
            end
        end
        lnk(1'b1, SBAFE_ADDR_CHGAIN, 16'h0E40);
        repeat (4) @(posedge hclk);
        chk("shared_hold", 2'h3, channel_gain_code[1]);
        lnk(1'b1, SBAFE_ADDR_GAIN, (SBAFE_GAIN_RST & 16'hFFBC) | 16'h0040);
        repeat (4) @(posedge hclk);
        for (int k = 0; k < 4; k++) chk("per_chan", k, channel_gain_code[k]);
        lnk(1'b1, SBAFE_ADDR_GAIN, (SBAFE_GAIN_RST & 16'hFFBC) | 16'h0002);
        repeat (4) @(posedge hclk);
        chk("shared_back", 2'h2, channel_gain_code[3]);
    endtask

    task automatic t_path();
        lnk(1'b1, SBAFE_ADDR_PATH, SBAFE_PATH_TIA);
        chk("good_wr", 4'hA, st);
        repeat (2) @(posedge hclk);
        chk("tia", 1'b1, path_tia_mode);
        chk("not_full", 1'b0, path_full_mode);
        lnk(1'b1, SBAFE_ADDR_PATH, 16'h1234);
        chk("refused", 4'hE, st);
        lnk(1'b0, SBAFE_ADDR_PATH, 16'h0);
        chk("path_kept", SBAFE_PATH_TIA, r);
        lnk(1'b1, SBAFE_ADDR_PATH, SBAFE_PATH_FULL);
        repeat (2) @(posedge hclk);
        chk("full_back", 1'b1, path_full_mode);
    endtask

    task automatic t_status();
        fifo_byte_count <= 8'h2A;
        fifo_word_threshold <= 6'd20;
        repeat (3) @(posedge hclk);
        chk("irq_above", 1'b1, fifo_irq);
        fifo_word_threshold <= 6'd21;
        repeat (3) @(posedge hclk);
        chk("irq_equal", 1'b0, fifo_irq);
        pulse(1'b1);
        chk("irq_open", 1, irq_cnt);
        second_slot_event_mask <= 1'b1;
        pulse(1'b1);
        chk("irq_masked", 1, irq_cnt);
        pulse(1'b0);
        st_rw(16'h0000, 16'h2A60);
        st_rw(16'h0040, 16'h2A20);
        st_rw(16'h009F, 16'h2A20);
        st_rw(16'h0020, 16'h2A00);
        lnk(1'b1, SBAFE_ADDR_STATUS, 16'h8000);
        chk("clr_off", 0, clr_cnt);
        fifo_host_access_enable <= 1'b1;
        lnk(1'b1, SBAFE_ADDR_STATUS, 16'h8000);
        chk("clr_on", 1, clr_cnt);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        if (fifo_clear === 1'b1) clr_cnt++;
        if (second_slot_irq === 1'b1) irq_cnt++;
    end

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (8000) @(posedge hclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fifo_byte_count = 8'h00;
        fifo_word_threshold = 6'h00;
        fifo_host_access_enable = 1'b0;
        first_slot_sample_done = 1'b0;
        second_slot_sample_done = 1'b0;
        second_slot_event_mask = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        do ahb(1'b0, SBAFE_HOFS_STATUS, 32'h0); while (x[3] !== 1'b1);
        t_init();
        t_gain();
        t_path();
        t_status();
        report_and_stop();
    end
endmodule // slot_b_afe_cfg_and_status_tb
